// File: hdl/ureq_params.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design files
`ifndef UREQ_PARAMS_SVH
`define UREQ_PARAMS_SVH

`define UREQ_OFF_AEQ_CTRL     8'h1c
`define UREQ_OFF_HOST_EQ      8'h21
`define UREQ_OFF_MISC         8'h22
`define UREQ_OFF_STATUS       8'h24

`define UREQ_RST_AEQ_CTRL     8'h05
`define UREQ_RST_HOST_EQ      8'h00
`define UREQ_RST_MISC         8'h04
`define UREQ_RST_STATUS       8'h01

`define UREQ_ADAPTIVE_EQUALIZER_ENABLE_BIT       0
`define UREQ_ADAPTATION_MODE_SELECT_LSB     1
`define UREQ_AEQ_OVR_BIT      7

`define UREQ_MISC_TERM_BIT    7
`define UREQ_MISC_LPI_LSB     5
`define UREQ_MISC_LPDIS_BIT   4
`define UREQ_MISC_DFPI_LSB    2
`define UREQ_MISC_WRSKIP_BIT  1
`define UREQ_MISC_CMPL_BIT    0

`define UREQ_ST_LONG_BIT      7
`define UREQ_ST_CMPL_BIT      3
`define UREQ_ST_U0_BIT        2
`define UREQ_ST_LP_BIT        1
`define UREQ_ST_DISC_BIT      0

// Detect intervals in milliseconds
`define UREQ_LP_MS0           8'd48
`define UREQ_LP_MS1           8'd84
`define UREQ_LP_MS2           8'd120
`define UREQ_LP_MS3           8'd156
`define UREQ_DFP_MS0          8'd4
`define UREQ_DFP_MS1          8'd6
`define UREQ_DFP_MS2          8'd36
`define UREQ_DFP_MS3          8'd84

// Clock rate in kHz equals cycles per millisecond
`define UREQ_CLK_KHZ          250000
`define UREQ_STRAP_WAIT       2'h3
// Arbitrary bus address
`define UREQ_I2C_ADDR         7'h44

`endif

// File: hdl/ureq_pkg.sv
// Types shared by the redriver register block
// Assumes the params header is on the include path
package ureq_pkg;

  typedef enum logic [2:0] {
    UREQ_IDLE,
    UREQ_ADDR,
    UREQ_ACK_ADDR,
    UREQ_PTR,
    UREQ_ACK_PTR,
    UREQ_WDATA,
    UREQ_RDATA,
    UREQ_ACK_R
  } ureq_i2c_st_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ureq_wr_t;

  typedef struct packed {
    logic enter_u0;
    logic enter_low_power;
    logic enter_disconnect;
    logic compliance_active;
    logic long_channel;
    logic in_low_power;
    logic in_rx_detect;
    logic polling_in_warm_reset;
  } ureq_link_t;

endpackage

// File: hdl/ureq_rxdet_timer.sv
// Repeating receiver-detect period timer, millisecond granularity
// Assumes enable and period come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ureq_params.svh"

module ureq_rxdet_timer #(
  parameter int MS_CYCLES = `UREQ_CLK_KHZ
) (
  input  wire logic       clk_i,        // system clock
  input  wire logic       rst_n_i,      // async reset, active low
  input  wire logic       enable_i,     // detect allowed
  input  wire logic [7:0] period_ms_i,  // period in ms
  output logic            trigger_o     // one-cycle detect request
);

  localparam int TW = $clog2(MS_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

  logic [TW-1:0] tick_r;
  logic [TW-1:0] tick_nxt;
  logic [7:0]    ms_r;
  logic [7:0]    ms_nxt;
  logic          trig_r;
  logic          trig_nxt;

  // Disable clears the count so a re-enable starts a full period
  always_comb begin
    tick_nxt = tick_r;
    ms_nxt   = ms_r;
    trig_nxt = 1'b0;
    if (!enable_i) begin
      tick_nxt = '0;
      ms_nxt   = '0;
    end else if (tick_r == TICK_LAST) begin
      tick_nxt = '0;
      // Compare with >= so a shortened period takes effect at once
      if (ms_r >= period_ms_i - 8'h01) begin
        ms_nxt   = '0;
        trig_nxt = 1'b1;
      end else begin
        ms_nxt = ms_r + 8'h01;
      end
    end else begin
      tick_nxt = tick_r + TW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_r <= '0;
      ms_r   <= '0;
      trig_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      ms_r   <= ms_nxt;
      trig_r <= trig_nxt;
    end
  end

  assign trigger_o = trig_r;

endmodule

`default_nettype wire

// File: hdl/ureq_i2c_slave.sv
// Two-wire configuration slave: pointer write, data write and read
// Assumes pins are asynchronous; read data is a mux on the pointer
`timescale 1ns/1ps
`default_nettype none
`include "ureq_params.svh"

module ureq_i2c_slave import ureq_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `UREQ_I2C_ADDR
) (
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_n_i,    // async reset, active low
  input  wire logic       scl_i,      // bus clock pin level
  input  wire logic       sda_i,      // bus data pin level
  output logic            sda_oe_o,   // high pulls data low
  output ureq_wr_t        bus_o,      // register write pulse
  output logic [7:0]      rd_addr_o,  // register read address
  input  wire logic [7:0] rdata_i     // register read data
);

  logic [1:0]   scl_sy;
  logic [1:0]   sda_sy;
  logic         scl_d;
  logic         sda_d;
  ureq_i2c_st_t st_r;
  ureq_i2c_st_t st_nxt;
  logic [3:0]   cnt_r;
  logic [3:0]   cnt_nxt;
  logic [7:0]   sh_r;
  logic [7:0]   sh_nxt;
  logic [7:0]   ptr_r;
  logic [7:0]   ptr_nxt;
  logic         oe_r;
  logic         oe_nxt;
  logic         rw_r;
  logic         rw_nxt;
  ureq_wr_t     wr_r;
  ureq_wr_t     wr_nxt;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;

  assign rise  = scl_sy[1] & ~scl_d;
  assign fall  = ~scl_sy[1] & scl_d;
  assign start = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  assign stop  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    oe_nxt  = oe_r;
    rw_nxt  = rw_r;
    wr_nxt  = '0;
    if (start) begin
      st_nxt  = UREQ_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt = UREQ_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        UREQ_ADDR, UREQ_PTR, UREQ_WDATA: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], sda_sy[1]};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b1;
            if (st_r == UREQ_ADDR) begin
              rw_nxt = sh_r[0];
              st_nxt = UREQ_ACK_ADDR;
              // Foreign address: stay silent until the next start
              if (sh_r[7:1] != DEV_ADDR) begin
                oe_nxt = 1'b0;
                st_nxt = UREQ_IDLE;
              end
            end else if (st_r == UREQ_PTR) begin
              ptr_nxt = sh_r;
              st_nxt  = UREQ_ACK_PTR;
            end else begin
              wr_nxt  = '{wr: 1'b1, addr: ptr_r, wdata: sh_r};
              ptr_nxt = ptr_r + 8'h01;
              st_nxt  = UREQ_ACK_PTR;
            end
          end
        end
        UREQ_ACK_ADDR: begin
          if (fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              sh_nxt = rdata_i;
              oe_nxt = ~rdata_i[7];
              st_nxt = UREQ_RDATA;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = UREQ_PTR;
            end
          end
        end
        UREQ_ACK_PTR: begin
          if (fall) begin
            oe_nxt = 1'b0;
            st_nxt = UREQ_WDATA;
          end
        end
        UREQ_RDATA: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt  = 1'b0;
              ptr_nxt = ptr_r + 8'h01;
              st_nxt  = UREQ_ACK_R;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        UREQ_ACK_R: begin
          // Master acknowledge asks for the next byte, a nack returns to idle
          if (rise && sda_sy[1]) begin
            st_nxt = UREQ_IDLE;
          end else if (rise) begin
            rw_nxt = 1'b1;
            st_nxt = UREQ_ACK_ADDR;
          end
        end
        default: st_nxt = UREQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      st_r   <= UREQ_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      ptr_r  <= 8'h00;
      oe_r   <= 1'b0;
      rw_r   <= 1'b0;
      wr_r   <= '0;
    end else begin
      scl_sy <= {scl_sy[0], scl_i};
      sda_sy <= {sda_sy[0], sda_i};
      scl_d  <= scl_sy[1];
      sda_d  <= sda_sy[1];
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      ptr_r  <= ptr_nxt;
      oe_r   <= oe_nxt;
      rw_r   <= rw_nxt;
      wr_r   <= wr_nxt;
    end
  end

  assign sda_oe_o  = oe_r;
  assign bus_o     = wr_r;
  assign rd_addr_o = ptr_r;

endmodule

`default_nettype wire

// File: hdl/ureq_regs.sv
// Equalizer select, detect policy and port one status registers
// Assumes link events come from the link state machine on clk_i
//
// How it works
// (RQ1) Select reads strap value while override clear
// (RQ2) Override set: write sets host equalizer
// (RQ3) Bit seven picks termination at detect start
// (RQ4) Low-power detect period 48 to 156 ms
// (RQ5) Disable bit stops low-power receiver detect
// (RQ6) Downstream detect period 4 to 84 ms
// (RQ7) Skip detect after warm-reset polling seen
// (RQ8) Bit zero disables compliance mode detection
// (RQ9) Status bit seven shows long channel while adaptive EQ is on in fast mode
// (RQ10) Status bit three mirrors compliance mode
// (RQ11) Status bit two set on U0 entry
// (RQ12) Status bit one set on U2/U3 entry
// (RQ13) Status bit zero set on disconnect
// (RQ14) Enable bit switches adaptive equalization
// (RQ15) Mode zero means fast adaptation
// (RQ16) Straps sampled once after reset release
`timescale 1ns/1ps
`default_nettype none
`include "ureq_params.svh"

module ureq_regs import ureq_pkg::*; #(
  parameter int         MS_CYCLES = `UREQ_CLK_KHZ,
  parameter logic [6:0] DEV_ADDR  = `UREQ_I2C_ADDR
) (
  input  wire logic       clk_i,                  // system clock
  input  wire logic       rst_n_i,                // async reset, low
  input  wire logic       scl_i,                  // bus clock pin
  input  wire logic       sda_i,                  // bus data pin in
  output logic            sda_o,                  // bus data pin out
  output logic            sda_oe_o,               // bus data enable
  input  wire logic [1:0] eq_strap_i,             // equalizer straps
  input  wire ureq_link_t link_i,                 // link state events
  output logic [3:0]      host_rx_eq_o,           // host rx EQ setting
  output logic            start_term_off_o,       // termination off
  output logic            rxdet_trigger_o,        // detect request
  output logic            skip_rxdet_o,           // skip detect
  output logic            compliance_detect_en_o, // compliance allowed
  output logic            aeq_enable_o,           // adaptive EQ on
  output logic            aeq_fast_mode_o         // fast adaptation
);

  ureq_wr_t   bus;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic [1:0] strap_meta;
  logic [1:0] strap_sy;
  logic [1:0] strap_wait_r;
  logic [1:0] strap_wait_nxt;
  logic       strap_done_r;
  logic       strap_done_nxt;
  logic [1:0] strap_val_r;
  logic [1:0] strap_val_nxt;
  logic [7:0] aeq_r;
  logic [7:0] aeq_nxt;
  logic [3:0] host_eq_r;
  logic [3:0] host_eq_nxt;
  logic [7:0] misc_r;
  logic [7:0] misc_nxt;
  logic [7:0] st_r;
  logic [7:0] st_nxt;
  logic       trig_r;
  logic       skip_r;
  logic       skip_nxt;
  logic       cmpl_en_r;
  logic       fast_r;
  logic       tmr_trig;
  logic       detect_en;
  logic [7:0] period_ms;
  logic       wr_aeq;
  logic       wr_host;
  logic       wr_misc;
  logic       wr_st;
  logic       fast_mode;

  ureq_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_oe_o  (sda_oe_o),
    .bus_o     (bus),
    .rd_addr_o (rd_addr),
    .rdata_i   (rdata)
  );

  // Open drain: the pin is only ever pulled low
  assign sda_o = 1'b0;

  assign wr_aeq  = bus.wr && bus.addr == `UREQ_OFF_AEQ_CTRL;
  assign wr_host = bus.wr && bus.addr == `UREQ_OFF_HOST_EQ;
  assign wr_misc = bus.wr && bus.addr == `UREQ_OFF_MISC;
  assign wr_st   = bus.wr && bus.addr == `UREQ_OFF_STATUS;
  // (RQ15) Fast mode decode
  assign fast_mode = aeq_r[`UREQ_ADAPTATION_MODE_SELECT_LSB+:2] == 2'h0;

  // Unmapped addresses read as zero
  always_comb begin
    case (rd_addr)
      `UREQ_OFF_AEQ_CTRL: rdata = aeq_r;
      `UREQ_OFF_HOST_EQ:  rdata = {4'h0, host_eq_r};
      `UREQ_OFF_MISC:     rdata = misc_r;
      `UREQ_OFF_STATUS:   rdata = st_r;
      default:            rdata = 8'h00;
    endcase
  end

  // Strap capture waits out the synchroniser before latching
  always_comb begin
    strap_wait_nxt = strap_wait_r;
    strap_done_nxt = strap_done_r;
    strap_val_nxt  = strap_val_r;
    // (RQ16) One capture per reset
    if (!strap_done_r) begin
      if (strap_wait_r == `UREQ_STRAP_WAIT) begin
        strap_val_nxt  = strap_sy;
        strap_done_nxt = 1'b1;
      end else begin
        strap_wait_nxt = strap_wait_r + 2'h1;
      end
    end
  end

  always_comb begin
    aeq_nxt     = aeq_r;
    host_eq_nxt = host_eq_r;
    misc_nxt    = misc_r;
    st_nxt      = st_r;
    // (RQ14) Adaptive enable and mode are software fields
    if (wr_aeq) begin
      aeq_nxt = bus.wdata & 8'h87;
    end
    // (RQ1) Strap value shown while not overridden
    if (!aeq_r[`UREQ_AEQ_OVR_BIT]) begin
      host_eq_nxt = {2'h0, strap_val_r};
    // (RQ2) Software write drives the equalizer
    end else if (wr_host) begin
      host_eq_nxt = bus.wdata[3:0];
    end
    // (RQ3) (RQ4) (RQ5) (RQ6) (RQ7) (RQ8) Plain policy bits
    if (wr_misc) begin
      misc_nxt = bus.wdata;
    end
    // Sticky flags clear by writing one; a new event wins
    if (wr_st) begin
      st_nxt[2:0] = st_r[2:0] & ~bus.wdata[2:0];
    end
    // (RQ11) U0 entry
    if (link_i.enter_u0) begin
      st_nxt[`UREQ_ST_U0_BIT] = 1'b1;
    end
    // (RQ12) Low-power entry
    if (link_i.enter_low_power) begin
      st_nxt[`UREQ_ST_LP_BIT] = 1'b1;
    end
    // (RQ13) Disconnect entry
    if (link_i.enter_disconnect) begin
      st_nxt[`UREQ_ST_DISC_BIT] = 1'b1;
    end
    // (RQ10) Compliance level
    st_nxt[`UREQ_ST_CMPL_BIT] = link_i.compliance_active;
    // (RQ9) Long channel only with fast adaptive EQ
    st_nxt[`UREQ_ST_LONG_BIT] = aeq_r[`UREQ_ADAPTIVE_EQUALIZER_ENABLE_BIT] & fast_mode &
                                link_i.long_channel;
    st_nxt[6:4] = 3'h0;
  end

  // (RQ4) (RQ6) Interval lookup per state
  always_comb begin
    period_ms = `UREQ_DFP_MS1;
    if (link_i.in_low_power) begin
      case (misc_r[`UREQ_MISC_LPI_LSB+:2])
        2'h0:    period_ms = `UREQ_LP_MS0;
        2'h1:    period_ms = `UREQ_LP_MS1;
        2'h2:    period_ms = `UREQ_LP_MS2;
        default: period_ms = `UREQ_LP_MS3;
      endcase
    end else begin
      case (misc_r[`UREQ_MISC_DFPI_LSB+:2])
        2'h0:    period_ms = `UREQ_DFP_MS0;
        2'h1:    period_ms = `UREQ_DFP_MS1;
        2'h2:    period_ms = `UREQ_DFP_MS2;
        default: period_ms = `UREQ_DFP_MS3;
      endcase
    end
  end

  // (RQ5) Low-power detect gated by the disable bit
  assign detect_en = link_i.in_low_power ? ~misc_r[`UREQ_MISC_LPDIS_BIT]
                                         : link_i.in_rx_detect;
  // (RQ7) Skip only when enabled and partner polled
  assign skip_nxt = misc_r[`UREQ_MISC_WRSKIP_BIT] &
                    link_i.polling_in_warm_reset;

  ureq_rxdet_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tmr (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .enable_i    (detect_en),
    .period_ms_i (period_ms),
    .trigger_o   (tmr_trig)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_meta   <= 2'h0;
      strap_sy     <= 2'h0;
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_val_r  <= 2'h0;
      aeq_r        <= `UREQ_RST_AEQ_CTRL;
      host_eq_r    <= 4'h0;
      misc_r       <= `UREQ_RST_MISC;
      st_r         <= `UREQ_RST_STATUS;
      trig_r       <= 1'b0;
      skip_r       <= 1'b0;
      cmpl_en_r    <= 1'b1;
      fast_r       <= 1'b0;
    end else begin
      strap_meta   <= eq_strap_i;
      strap_sy     <= strap_meta;
      strap_wait_r <= strap_wait_nxt;
      strap_done_r <= strap_done_nxt;
      strap_val_r  <= strap_val_nxt;
      aeq_r        <= aeq_nxt;
      host_eq_r    <= host_eq_nxt;
      misc_r       <= misc_nxt;
      st_r         <= st_nxt;
      trig_r       <= tmr_trig;
      skip_r       <= skip_nxt;
      // (RQ8) Compliance detection allowed only when bit clear
      cmpl_en_r    <= ~misc_r[`UREQ_MISC_CMPL_BIT];
      fast_r       <= fast_mode;
    end
  end

  assign host_rx_eq_o           = host_eq_r;
  assign start_term_off_o       = misc_r[`UREQ_MISC_TERM_BIT];
  assign rxdet_trigger_o        = trig_r;
  assign skip_rxdet_o           = skip_r;
  assign compliance_detect_en_o = cmpl_en_r;
  assign aeq_enable_o           = aeq_r[`UREQ_ADAPTIVE_EQUALIZER_ENABLE_BIT];
  assign aeq_fast_mode_o        = fast_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  strap_readback_a: assert property ( // RQ1
    strap_done_r && !aeq_r[`UREQ_AEQ_OVR_BIT] |=>
      host_rx_eq_o == {2'h0, $past(strap_val_r)})
    else $error("select field differs from strap value");
  eq_write_a: assert property ( // RQ2
    wr_host && aeq_r[`UREQ_AEQ_OVR_BIT] |=>
      host_rx_eq_o == $past(bus.wdata[3:0]))
    else $error("override write not applied");
  term_select_a: assert property ( // RQ3
    wr_misc |-> ##1 start_term_off_o == $past(bus.wdata[7]))
    else $error("termination choice not applied");
  lp_period_a: assert property ( // RQ4
    link_i.in_low_power && misc_r[6:5] == 2'h3 |-> period_ms == 8'd156)
    else $error("low-power interval wrong");
  lp_disable_a: assert property ( // RQ5
    link_i.in_low_power && misc_r[4] |-> ##2 !rxdet_trigger_o)
    else $error("detect issued while disabled");
  dfp_period_a: assert property ( // RQ6
    !link_i.in_low_power && misc_r[3:2] == 2'h0 |-> period_ms == 8'd4)
    else $error("downstream interval wrong");
  warm_skip_a: assert property ( // RQ7
    link_i.polling_in_warm_reset && misc_r[1] |=> skip_rxdet_o)
    else $error("warm reset skip missing");
  cmpl_ctrl_a: assert property ( // RQ8
    wr_misc && bus.wdata[0] |-> ##2 !compliance_detect_en_o)
    else $error("compliance detect not disabled");
  long_flag_a: assert property ( // RQ9
    !aeq_r[0] |=> !st_r[`UREQ_ST_LONG_BIT])
    else $error("long flag set without adaptive EQ");
  cmpl_stat_a: assert property ( // RQ10
    ##1 st_r[`UREQ_ST_CMPL_BIT] == $past(link_i.compliance_active))
    else $error("compliance status wrong");
  u0_flag_a: assert property ( // RQ11
    link_i.enter_u0 |=> st_r[`UREQ_ST_U0_BIT])
    else $error("U0 flag lost");
  lp_flag_a: assert property ( // RQ12
    link_i.enter_low_power |=> st_r[`UREQ_ST_LP_BIT])
    else $error("low-power flag lost");
  disc_flag_a: assert property ( // RQ13
    link_i.enter_disconnect |=> st_r[`UREQ_ST_DISC_BIT])
    else $error("disconnect flag lost");
  fast_out_a: assert property ( // RQ15
    aeq_r[2:1] == 2'h0 |=> aeq_fast_mode_o)
    else $error("fast mode not reported");
  strap_hold_a: assert property ( // RQ16
    strap_done_r |=> $stable(strap_val_r) && strap_done_r)
    else $error("strap value changed after capture");

endmodule

`default_nettype wire

// File: verification/ureq_bus_master.sv
// Two-wire bus master standing in for the system processor
// Assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none

module ureq_bus_master (
  input  wire logic clk_i,     // system clock
  input  wire logic sda_i,     // resolved data wire
  output logic      scl_o,     // bus clock
  output logic      sda_low_o  // high pulls data low
);
  localparam logic [6:0] ADDR = 7'h44;
  int nack_count;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nack_count = 0;
  end

  // Six clk per phase; the slave synchroniser needs three
  task automatic hold();
    repeat (6) @(negedge clk_i);
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b0;
    hold();
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda_low_o = ~b;
    hold();
    scl_o = 1'b1;
    hold();
    s = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic byte_wr(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    if (s !== 1'b0) begin
      nack_count++;
    end
  endtask

  // Any device address, so refusal of a foreign one can be tested
  task automatic wr_dev(input logic [6:0] dev, input logic [7:0] a,
                        input logic [7:0] d);
    start();
    byte_wr({dev, 1'b0});
    byte_wr(a);
    byte_wr(d);
    stop();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr_dev(ADDR, a, d);
  endtask

  // Single byte read, ended by a master nack
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic s;
    start();
    byte_wr({ADDR, 1'b0});
    byte_wr(a);
    start();
    byte_wr({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, s);
    stop();
  endtask
endmodule

`default_nettype wire

// File: verification/usb_redriver_eq_rxdet_regs_tb_top.sv
// Self-checking bench for the redriver register block
// Assumes a shortened millisecond so detect periods stay brief
`timescale 1ns/1ps
`default_nettype none

module usb_redriver_eq_rxdet_regs_tb_top import ureq_pkg::*;;
  localparam int MSC = 4;
  logic       clk;
  logic       rst_n;
  logic       scl;
  logic       sda_low;
  logic       sda_drv;
  logic       sda_oe;
  wire logic  sda_w;
  logic [1:0] strap;
  ureq_link_t link;
  logic [3:0] host_eq;
  logic       term_off;
  logic       trig;
  logic       skip;
  logic       cmpl_en;
  logic       adaptive_equalizer_enable;
  logic       fast;
  int         miscompares;
  int         cmp_count;
  int         dfp_ms[4] = '{4, 6, 36, 84};
  int         lp_ms[4] = '{48, 84, 120, 156};

  // Open drain with pull-up: low if either side pulls
  assign sda_w = (sda_oe ? sda_drv : 1'b1) & ~sda_low;

  always #2 clk = ~clk;

  ureq_regs #(.MS_CYCLES(MSC)) dut_u (
    .clk_i                  (clk),
    .rst_n_i                (rst_n),
    .scl_i                  (scl),
    .sda_i                  (sda_w),
    .sda_o                  (sda_drv),
    .sda_oe_o               (sda_oe),
    .eq_strap_i             (strap),
    .link_i                 (link),
    .host_rx_eq_o           (host_eq),
    .start_term_off_o       (term_off),
    .rxdet_trigger_o        (trig),
    .skip_rxdet_o           (skip),
    .compliance_detect_en_o (cmpl_en),
    .aeq_enable_o           (adaptive_equalizer_enable),
    .aeq_fast_mode_o        (fast)
  );

  ureq_bus_master bus_u (
    .clk_i     (clk),
    .sda_i     (sda_w),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_u.rd_reg(a, d);
    check($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
  endtask

  task automatic wait_trig(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (trig !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      test_done();
    end
  endtask

  // First gap may straddle the period change, so measure the third
  task automatic period_chk(input int ms);
    int n;
    wait_trig(n);
    wait_trig(n);
    wait_trig(n);
    check("detect period", n[15:0], ms[15:0] * MSC[15:0]);
  endtask

  task automatic pulse_u0_lp();
    @(negedge clk);
    link.enter_u0 = 1'b1;
    link.enter_low_power = 1'b1;
    @(negedge clk);
    link.enter_u0 = 1'b0;
    link.enter_low_power = 1'b0;
  endtask

  initial begin
    int c;
    clk = 1'b0;
    rst_n = 1'b0;
    strap = 2'b10;
    link = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("host eq", host_eq, 4'h2);
    rd_chk(8'h21, 8'h02);
    rd_chk(8'h22, 8'h04);
    rd_chk(8'h24, 8'h01);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h1c, 8'h05);
    check("aeq enable", adaptive_equalizer_enable, 1'b1);
    check("fast mode", fast, 1'b0);
    // Foreign address: three bytes refused, register untouched
    bus_u.wr_dev(7'h45, 8'h22, 8'hff);
    rd_chk(8'h22, 8'h04);
    strap = 2'b01;
    repeat (10) @(negedge clk);
    check("host eq", host_eq, 4'h2);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("host eq", host_eq, 4'h1);
    bus_u.wr_reg(8'h21, 8'h0b);
    rd_chk(8'h21, 8'h01);
    bus_u.wr_reg(8'h1c, 8'h80);
    check("aeq enable", adaptive_equalizer_enable, 1'b0);
    check("fast mode", fast, 1'b1);
    bus_u.wr_reg(8'h21, 8'h0b);
    rd_chk(8'h21, 8'h0b);
    check("host eq", host_eq, 4'hb);
    link.long_channel = 1'b1;
    link.compliance_active = 1'b1;
    pulse_u0_lp();
    rd_chk(8'h24, 8'h0f);
    bus_u.wr_reg(8'h1c, 8'h81);
    rd_chk(8'h24, 8'h8f);
    bus_u.wr_reg(8'h24, 8'hff);
    link.compliance_active = 1'b0;
    rd_chk(8'h24, 8'h80);
    @(negedge clk);
    link.enter_disconnect = 1'b1;
    @(negedge clk);
    link.enter_disconnect = 1'b0;
    bus_u.wr_reg(8'h1c, 8'h83);
    rd_chk(8'h24, 8'h01);
    pulse_u0_lp();
    rd_chk(8'h24, 8'h07);
    link.polling_in_warm_reset = 1'b1;
    bus_u.wr_reg(8'h22, 8'h83);
    check("term off", term_off, 1'b1);
    check("skip detect", skip, 1'b1);
    check("compliance en", cmpl_en, 1'b0);
    bus_u.wr_reg(8'h22, 8'h00);
    check("term off", term_off, 1'b0);
    check("skip detect", skip, 1'b0);
    check("compliance en", cmpl_en, 1'b1);
    link.in_rx_detect = 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus_u.wr_reg(8'h22, {4'h0, k[1:0], 2'b00});
      period_chk(dfp_ms[k]);
    end
    link.in_low_power = 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus_u.wr_reg(8'h22, {1'b0, k[1:0], 5'h00});
      period_chk(lp_ms[k]);
    end
    bus_u.wr_reg(8'h22, 8'h10);
    c = 0;
    repeat (800) begin
      @(negedge clk);
      if (trig === 1'b1) c++;
    end
    check("triggers when off", c[15:0], 16'h0000);
    check("nacks", bus_u.nack_count[15:0], 16'h0003);
    test_done();
  end
endmodule

`default_nettype wire
